/* File: design/cer_map.svh */
/*
 Offsets, field positions, codes, reset values and timing counts of the
 completion error reporter. Included by the package and the top module.
*/
// How it works
// [R1] Payload error flagged by discontinue on last beat
// [R2] Internal storage read error raises discontinue
// [R3] User logic drops whole discontinued packet
// [R4] Discontinue from read error is fatal
// [R5] No second start in a discontinue beat
// [R6] Completions matched to table, headers checked
// [R7] Four-bit code in descriptor, zero means clean
// [R8] Bit 30 marks final completion of request
// [R9] Poisoned completion gives code 0001
// [R10] UR, CA or CRS status gives 0010
// [R11] Byte count mismatch gives 0011, completed
// [R12] Requester ID, TC or Attr mismatch gives 0100
// [R13] Wrong low address gives 0101
// [R14] Unknown tag gives 0110
// [R15] Too many bytes gives 0111, completed
// [R16] Per-request timer, expiry emits 1001 dummy
// [R17] Dummy carries only completed, tag, function
// [R18] Function reset emits 1000 dummy per request
// [R19] User may end or retry timed-out request
// [R20] User keeps tag until completed flag seen
// [R21] Codes 1010 and above never emitted
`ifndef CER_MAP_SVH
`define CER_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses) and fields
// ----------------------------------------------------------------
`define CER_OFS_CTRL 4'h0
`define CER_OFS_STAT 4'h4
`define CER_OFS_ERRS 4'h8
`define CER_CTRL_TMR_EN 0
`define CER_CTRL_RST 32'h0000_0001
`define CER_STAT_FATAL 0
`define CER_STAT_OUT_LSB 8

// ----------------------------------------------------------------
// Descriptor layout
// ----------------------------------------------------------------
`define CER_DESC_W 96
`define CER_D_ADDR 0
`define CER_D_CODE 12
`define CER_D_BC 16
`define CER_D_RC 30
`define CER_D_STS 43
`define CER_D_POIS 46
`define CER_D_FUNC 48
`define CER_D_TAG 64
`define CER_D_TC 89
`define CER_D_ATTR 92

// ----------------------------------------------------------------
// Error codes and status values
// ----------------------------------------------------------------
`define CER_CODE_OK 4'h0
`define CER_CODE_POIS 4'h1
`define CER_CODE_TERM 4'h2
`define CER_CODE_BCNT 4'h3
`define CER_CODE_HDR 4'h4
`define CER_CODE_ADDR 4'h5
`define CER_CODE_TAG 4'h6
`define CER_CODE_OVER 4'h7
`define CER_CODE_FLR 4'h8
`define CER_CODE_TMO 4'h9
`define CER_STS_SC 3'h0

// ----------------------------------------------------------------
// Table size and completion timeout
// ----------------------------------------------------------------
`define CER_TAG_W 4
`define CER_CLK_MHZ 100
`define CER_TMO_US 50000
`define CER_TMO_CYC (`CER_TMO_US * `CER_CLK_MHZ)

`endif

/* File: design/cer_pkg.sv */
/*
 Types of the completion error reporter.
 Assumes cer_map.svh is on the include path.
*/
`include "cer_map.svh"

package cer_pkg;
	// Error codes that can ever leave the block; nothing above 1001 [R21]
	typedef enum logic [3:0] {
		CER_OK = `CER_CODE_OK,
		CER_POIS = `CER_CODE_POIS,
		CER_TERM = `CER_CODE_TERM,
		CER_BCNT = `CER_CODE_BCNT,
		CER_HDR = `CER_CODE_HDR,
		CER_ADDR = `CER_CODE_ADDR,
		CER_TAG = `CER_CODE_TAG,
		CER_OVER = `CER_CODE_OVER,
		CER_FLR = `CER_CODE_FLR,
		CER_TMO = `CER_CODE_TMO
	} cer_code_type;
endpackage

/* File: design/cer_top.sv */
/*
 Requester completion checker: split completion table, header checks,
 descriptor generation with error codes, timeout and function-reset
 dummies, and discontinue marking of payload beats.
 Assumes all inputs come from logic on clk; a single descriptor slot.
*/
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`include "cer_map.svh"

module cer_top #(
	parameter int TAG_W = `CER_TAG_W,
	parameter int TMO_CYC = `CER_TMO_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Avalon-MM register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Request issue
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_tag,
	input wire logic [7:0] req_func,
	input wire logic [15:0] req_rid,
	input wire logic [2:0] req_tc,
	input wire logic [2:0] req_attr,
	input wire logic [6:0] req_laddr,
	input wire logic [12:0] req_bytes,
	// Completion header from the link
	input wire logic cpl_valid,
	output logic cpl_ready,
	input wire logic [7:0] cpl_tag,
	input wire logic [15:0] cpl_rid,
	input wire logic [2:0] cpl_tc,
	input wire logic [2:0] cpl_attr,
	input wire logic [2:0] cpl_status,
	input wire logic cpl_poison,
	input wire logic [12:0] cpl_bc,
	input wire logic [6:0] cpl_laddr,
	input wire logic [12:0] cpl_len,
	// Function-level reset
	input wire logic flr_valid,
	input wire logic [7:0] flr_func,
	// Descriptor out
	output logic desc_valid,
	input wire logic desc_ready,
	output logic [`CER_DESC_W-1:0] desc_data,
	// Payload beats in and out
	input wire logic pld_valid,
	input wire logic pld_last,
	input wire logic pld_sof1,
	input wire logic pld_rd_err,
	output logic beat_valid,
	output logic [2:0] requester_completion_sideband
);
	import cer_pkg::*;

	localparam int NT = 1 << TAG_W;

	// ------------------------------------------------------------
	// Split completion table
	// ------------------------------------------------------------
	logic [NT-1:0] vld_reg, vld_next, tmo_reg, tmo_next, flr_reg, flr_next;
	logic [7:0] func_reg [NT], func_next [NT];
	logic [15:0] rid_reg [NT], rid_next [NT];
	logic [2:0] tc_reg [NT], tc_next [NT], attr_reg [NT], attr_next [NT];
	logic [6:0] addr_reg [NT], addr_next [NT];
	logic [12:0] rem_reg [NT], rem_next [NT];
	logic [31:0] tmr_reg [NT], tmr_next [NT];
	logic desc_valid_next, beat_valid_next, pkt_err_reg, pkt_err_next;
	logic [`CER_DESC_W-1:0] desc_next;
	logic [2:0] sb_next;
	logic [31:0] ctrl_reg, ctrl_next, errs_reg, errs_next, rdata_next;
	logic fatal_reg, fatal_next, ack_reg, ack_next;
	logic cpl_go, dmy_go, hit, rc, disc;
	logic [TAG_W-1:0] ci, di;
	cer_code_type code;
	logic [7:0] outst;

	// Tag lies inside the table
	function automatic logic in_range(input logic [7:0] t);
		return (t >> TAG_W) == 8'h0;
	endfunction

	// Slot is free once the previous descriptor is taken
	assign cpl_ready = !desc_valid || desc_ready;
	assign req_ready = in_range(req_tag) && !vld_reg[req_tag[TAG_W-1:0]];
	assign ci = cpl_tag[TAG_W-1:0];
	assign hit = in_range(cpl_tag) && vld_reg[ci];
	assign cpl_go = cpl_valid && cpl_ready;

	// Lowest flagged entry gets the next dummy
	always_comb begin
		di = '0;
		for (int i = NT - 1; i >= 0; i--) begin
			if (tmo_reg[i] || flr_reg[i]) begin
				di = TAG_W'(i);
			end
		end
	end
	// Link completions take priority; dummies only fill idle slots
	assign dmy_go = cpl_ready && !cpl_valid && |(tmo_reg | flr_reg);

	// Header checks, most severe first
	always_comb begin
		code = CER_OK;
		rc = 1'b0;
		if (!hit) begin
			code = CER_TAG; // [R14]
		end else if (cpl_rid != rid_reg[ci] || cpl_tc != tc_reg[ci] || cpl_attr != attr_reg[ci]) begin
			code = CER_HDR; // [R12]
		end else if (cpl_status != `CER_STS_SC) begin
			code = CER_TERM; // [R10]
			rc = 1'b1;
		end else if (cpl_len > rem_reg[ci] || cpl_bc > rem_reg[ci]) begin
			code = CER_OVER; // [R15]
			rc = 1'b1;
		end else if (cpl_bc != rem_reg[ci]) begin
			code = CER_BCNT; // [R11]
			rc = 1'b1;
		end else if (cpl_laddr != addr_reg[ci]) begin
			code = CER_ADDR; // [R13]
		end else begin
			code = cpl_poison ? CER_POIS : CER_OK; // [R9]
			rc = cpl_len == rem_reg[ci]; // [R8]
		end
	end

	// Table next state
	always_comb begin
		vld_next = vld_reg;
		tmo_next = tmo_reg;
		flr_next = flr_reg;
		func_next = func_reg;
		rid_next = rid_reg;
		tc_next = tc_reg;
		attr_next = attr_reg;
		addr_next = addr_reg;
		rem_next = rem_reg;
		tmr_next = tmr_reg;
		for (int i = 0; i < NT; i++) begin
			// Timer runs only while enabled, the request is open and no timeout is pending
			if (vld_reg[i] && !tmo_reg[i] && ctrl_reg[`CER_CTRL_TMR_EN]) begin
				tmr_next[i] = tmr_reg[i] + 32'h1;
				if (tmr_reg[i] == 32'(TMO_CYC - 1)) begin
					tmo_next[i] = 1'b1; // [R16]
				end
			end
			if (flr_valid && vld_reg[i] && func_reg[i] == flr_func) begin
				flr_next[i] = 1'b1; // [R18]
			end
		end
		if (req_valid && req_ready) begin
			vld_next[req_tag[TAG_W-1:0]] = 1'b1;
			tmo_next[req_tag[TAG_W-1:0]] = 1'b0;
			flr_next[req_tag[TAG_W-1:0]] = 1'b0;
			func_next[req_tag[TAG_W-1:0]] = req_func;
			rid_next[req_tag[TAG_W-1:0]] = req_rid;
			tc_next[req_tag[TAG_W-1:0]] = req_tc;
			attr_next[req_tag[TAG_W-1:0]] = req_attr;
			addr_next[req_tag[TAG_W-1:0]] = req_laddr;
			rem_next[req_tag[TAG_W-1:0]] = req_bytes;
			tmr_next[req_tag[TAG_W-1:0]] = 32'h0;
		end
		if (cpl_go && hit) begin
			// Lookup result updates the matched request [R6]
			if (rc) begin
				vld_next[ci] = 1'b0;
				tmo_next[ci] = 1'b0;
				flr_next[ci] = 1'b0;
			end else if (code == CER_OK || code == CER_POIS) begin
				rem_next[ci] = rem_reg[ci] - cpl_len;
				addr_next[ci] = addr_reg[ci] + cpl_len[6:0];
			end
		end else if (dmy_go) begin
			vld_next[di] = 1'b0;
			tmo_next[di] = 1'b0;
			flr_next[di] = 1'b0;
		end
	end

	// Descriptor slot
	always_comb begin
		desc_valid_next = desc_valid && !desc_ready;
		desc_next = desc_data;
		if (cpl_go) begin
			desc_valid_next = 1'b1;
			desc_next = '0;
			desc_next[`CER_D_ADDR+:7] = cpl_laddr;
			desc_next[`CER_D_CODE+:4] = code; // [R7]
			desc_next[`CER_D_BC+:13] = cpl_bc;
			desc_next[`CER_D_RC] = rc;
			desc_next[`CER_D_STS+:3] = cpl_status;
			desc_next[`CER_D_POIS] = cpl_poison;
			desc_next[`CER_D_FUNC+:8] = hit ? func_reg[ci] : 8'h0;
			desc_next[`CER_D_TAG+:8] = cpl_tag;
			desc_next[`CER_D_TC+:3] = cpl_tc;
			desc_next[`CER_D_ATTR+:3] = cpl_attr;
		end else if (dmy_go) begin
			// Only completed, tag and function are meaningful [R17]
			desc_valid_next = 1'b1;
			desc_next = '0;
			desc_next[`CER_D_CODE+:4] = flr_reg[di] ? `CER_CODE_FLR : `CER_CODE_TMO;
			desc_next[`CER_D_RC] = 1'b1;
			desc_next[`CER_D_FUNC+:8] = func_reg[di];
			desc_next[`CER_D_TAG+:8] = 8'(di);
		end
	end

	// Payload path: remember read errors until the last beat
	always_comb begin
		disc = pld_valid && pld_last && (pkt_err_reg || pld_rd_err); // [R1] [R2]
		pkt_err_next = pkt_err_reg;
		if (pld_valid) begin
			pkt_err_next = !pld_last && (pkt_err_reg || pld_rd_err);
		end
		beat_valid_next = pld_valid;
		sb_next = {pld_valid && pld_sof1 && !disc, pld_valid && pld_last, disc}; // [R5]
	end

	// Register slave: one wait cycle, answer on the next
	always_comb begin
		outst = '0;
		for (int i = 0; i < NT; i++) begin
			outst = outst + 8'(vld_reg[i]);
		end
		ack_next = (avs_read || avs_write) && !ack_reg;
		ctrl_next = ctrl_reg;
		// Event wins over a clear in the same cycle
		fatal_next = fatal_reg;
		if (avs_write && ack_reg && avs_address == `CER_OFS_STAT && avs_writedata[`CER_STAT_FATAL]) begin
			fatal_next = 1'b0;
		end
		if (disc) begin
			fatal_next = 1'b1; // [R4]
		end
		if (avs_write && ack_reg && avs_address == `CER_OFS_CTRL) begin
			ctrl_next = {31'h0, avs_writedata[`CER_CTRL_TMR_EN]};
		end
		errs_next = errs_reg;
		if (desc_valid_next && !(desc_valid && !desc_ready) && desc_next[`CER_D_CODE+:4] != `CER_CODE_OK) begin
			errs_next = errs_reg + 32'h1;
		end
		rdata_next = 32'h0;
		case (avs_address)
			`CER_OFS_CTRL: rdata_next = ctrl_reg;
			`CER_OFS_STAT: rdata_next = {16'h0, outst, 7'h0, fatal_reg};
			`CER_OFS_ERRS: rdata_next = errs_reg;
			default: rdata_next = 32'h0;
		endcase
	end
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

	// State registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vld_reg <= '0;
			tmo_reg <= '0;
			flr_reg <= '0;
			for (int i = 0; i < NT; i++) begin
				func_reg[i] <= 8'h0;
				rid_reg[i] <= 16'h0;
				tc_reg[i] <= 3'h0;
				attr_reg[i] <= 3'h0;
				addr_reg[i] <= 7'h0;
				rem_reg[i] <= 13'h0;
				tmr_reg[i] <= 32'h0;
			end
			desc_valid <= 1'b0;
			desc_data <= '0;
			pkt_err_reg <= 1'b0;
			beat_valid <= 1'b0;
			requester_completion_sideband <= 3'h0;
			ctrl_reg <= `CER_CTRL_RST;
			errs_reg <= 32'h0;
			fatal_reg <= 1'b0;
			ack_reg <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			vld_reg <= vld_next;
			tmo_reg <= tmo_next;
			flr_reg <= flr_next;
			func_reg <= func_next;
			rid_reg <= rid_next;
			tc_reg <= tc_next;
			attr_reg <= attr_next;
			addr_reg <= addr_next;
			rem_reg <= rem_next;
			tmr_reg <= tmr_next;
			desc_valid <= desc_valid_next;
			desc_data <= desc_next;
			pkt_err_reg <= pkt_err_next;
			beat_valid <= beat_valid_next;
			requester_completion_sideband <= sb_next;
			ctrl_reg <= ctrl_next;
			errs_reg <= errs_next;
			fatal_reg <= fatal_next;
			ack_reg <= ack_next;
			avs_readdata <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_disc_last_only: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		requester_completion_sideband[0] |-> requester_completion_sideband[1])
		else $error("discontinue outside last beat");
	a_disc_on_err: assert property (@(posedge clk) disable iff (!rstn) // [R2]
		pld_valid && pld_last && pld_rd_err |=> requester_completion_sideband[0])
		else $error("read error not marked");
	a_disc_fatal: assert property (@(posedge clk) disable iff (!rstn) // [R4]
		requester_completion_sideband[0] |-> fatal_reg)
		else $error("discontinue without fatal");
	a_no_second_sof: assert property (@(posedge clk) disable iff (!rstn) // [R5]
		requester_completion_sideband[0] |-> !requester_completion_sideband[2])
		else $error("second start beside discontinue");
	a_desc_held: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		desc_valid && !desc_ready |=> desc_valid && $stable(desc_data))
		else $error("descriptor dropped while stalled");
	a_bad_tag: assert property (@(posedge clk) disable iff (!rstn) // [R14]
		cpl_go && !hit |=> desc_data[`CER_D_CODE+:4] == `CER_CODE_TAG && !desc_data[`CER_D_RC])
		else $error("unknown tag not reported");
	a_term_done: assert property (@(posedge clk) disable iff (!rstn) // [R10]
		desc_valid && desc_data[`CER_D_CODE+:4] inside {4'h2, 4'h3, 4'h7, 4'h8, 4'h9} |-> desc_data[`CER_D_RC])
		else $error("terminating code without completed");
	a_code_legal: assert property (@(posedge clk) disable iff (!rstn) // [R21]
		desc_valid |-> desc_data[`CER_D_CODE+:4] <= 4'h9)
		else $error("reserved code emitted");
	a_flr_dummy: assert property (@(posedge clk) disable iff (!rstn) // [R18]
		dmy_go && flr_reg[di] |=> desc_data[`CER_D_CODE+:4] == `CER_CODE_FLR && desc_data[`CER_D_BC+:13] == 13'h0)
		else $error("function reset dummy wrong");
	a_rc_frees: assert property (@(posedge clk) disable iff (!rstn) // [R8]
		cpl_go && hit && rc |=> !vld_reg[$past(ci)])
		else $error("completed request still held");
endmodule

/* File: dv/cer_user_model.sv */
/*
 Model of the user logic that consumes the requester completion stream.
 Assumes one clock shared with the reporter and an active-low reset.
*/
module cer_user_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Descriptor stream
	input wire logic desc_valid,
	output logic desc_ready,
	input wire logic [95:0] desc_data,
	input wire logic stall,
	// Payload sideband
	input wire logic beat_valid,
	input wire logic [2:0] sideband,
	// Observations for the bench
	output logic [95:0] got_desc,
	output int got_cnt,
	output int drop_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [255:0] dropping;

	// Slow consumer when asked, to exercise back-pressure
	assign desc_ready = !stall;

	// ----------------------------------------
	// Descriptor capture and drop tracking
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			got_desc <= '0;
			got_cnt <= 0;
			drop_cnt <= 0;
			dropping <= '0;
		end else begin
			if (desc_valid && desc_ready) begin
				got_desc <= desc_data;
				got_cnt <= got_cnt + 1;
				// Tag stays closed until completed; timed-out requests simply end
				dropping[desc_data[71:64]] <= desc_data[15:12] != 4'h0 && !desc_data[30];
			end
			// Whole packet thrown away when its last beat is discontinued
			if (beat_valid && sideband[1:0] == 2'b11)
				drop_cnt <= drop_cnt + 1;
		end
	end
endmodule

/* File: dv/completion_error_reporter_test.sv */
/*
 Self-checking bench of the completion error reporter.
 Assumes cer_top and cer_user_model are compiled first.
*/
module completion_error_reporter_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TMO = 20;
	localparam logic [15:0] RID = 16'h0100;
	logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [3:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, rd;
	logic req_valid = 0, req_ready, cpl_valid = 0, cpl_ready, cpl_poison = 0, flr_valid = 0;
	logic [7:0] req_tag = 0, req_func = 0, cpl_tag = 0, flr_func = 0;
	logic [15:0] req_rid = 0, cpl_rid = 0;
	logic [2:0] req_tc = 0, req_attr = 0, cpl_tc = 0, cpl_attr = 0, cpl_status = 0;
	logic [6:0] req_laddr = 0, cpl_laddr = 0;
	logic [12:0] req_bytes = 0, cpl_bc = 0, cpl_len = 0;
	logic desc_valid, desc_ready, stall = 0, beat_valid;
	logic [95:0] desc_data, got_desc;
	logic pld_valid = 0, pld_last = 0, pld_sof1 = 0, pld_rd_err = 0;
	logic [2:0] requester_completion_sideband;
	int miscompares = 0, checks = 0, cycles = 0, got_cnt, drop_cnt;

	cer_top #(.TMO_CYC(TMO)) DUT (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .req_valid, .req_ready, .req_tag, .req_func, .req_rid, .req_tc,
		.req_attr, .req_laddr, .req_bytes, .cpl_valid, .cpl_ready, .cpl_tag, .cpl_rid, .cpl_tc, .cpl_attr,
		.cpl_status, .cpl_poison, .cpl_bc, .cpl_laddr, .cpl_len, .flr_valid, .flr_func, .desc_valid,
		.desc_ready, .desc_data, .pld_valid, .pld_last, .pld_sof1, .pld_rd_err, .beat_valid,
		.requester_completion_sideband);
	cer_user_model USR (.clk, .rstn, .desc_valid, .desc_ready, .desc_data, .stall, .beat_valid,
		.sideband(requester_completion_sideband), .got_desc, .got_cnt, .drop_cnt);

	// ----------------------------------------
	// Clock, watchdog and shared tasks
	// ----------------------------------------
	always #5 clk = ~clk;

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [95:0] got, input logic [95:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Avalon access; waitrequest polled at each rising edge, read data taken at the accepting one
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge clk);
	endtask

	task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
		bus(0, a, 0);
		chk(nm, rd, exp);
	endtask

	// Eight-byte request from address zero
	task automatic req(input logic [7:0] t, input logic [7:0] f);
		req_valid <= 1;
		req_tag <= t;
		req_func <= f;
		req_rid <= RID;
		req_bytes <= 13'h8;
		@(posedge clk);
		while (req_ready !== 1'b1) @(posedge clk);
		req_valid <= 0;
		@(posedge clk);
	endtask

	task automatic cpl(input logic [7:0] t, input logic [15:0] r, input logic [2:0] s, input logic p,
		input logic [12:0] bc, input logic [6:0] la, input logic [12:0] len, input logic [3:0] code,
		input logic rc);
		int n;
		n = got_cnt;
		cpl_valid <= 1;
		cpl_tag <= t;
		cpl_rid <= r;
		cpl_status <= s;
		cpl_poison <= p;
		cpl_bc <= bc;
		cpl_laddr <= la;
		cpl_len <= len;
		@(posedge clk);
		while (cpl_ready !== 1'b1) @(posedge clk);
		cpl_valid <= 0;
		if (stall) begin
			repeat (2) @(negedge clk);
			chk("cpl_ready", cpl_ready, 0);
			@(posedge clk);
			stall <= 0;
		end
		while (got_cnt == n) @(negedge clk);
		chk("code", got_desc[15:12], code);
		chk("completed", got_desc[30], rc);
		chk("tag", got_desc[71:64], t);
		@(posedge clk);
	endtask

	// Dummy descriptor: only code, completed, function and tag may be set
	task automatic dum(input logic [7:0] t, input logic [7:0] f, input logic [3:0] code);
		int n;
		n = got_cnt;
		while (got_cnt == n) @(negedge clk);
		chk("dummy", got_desc, (96'(t) << 64) | (96'(f) << 48) | (96'h1 << 30) | (96'(code) << 12));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_checks();
		req(1, 3);
		stall <= 1;
		cpl(1, RID, 0, 0, 8, 0, 4, 0, 0);
		cpl(1, RID, 0, 0, 4, 4, 4, 0, 1);
		req(2, 3);
		cpl(2, RID, 0, 1, 8, 0, 8, 1, 1);
		req(3, 3);
		cpl(3, RID, 1, 0, 8, 0, 0, 2, 1);
		req(4, 3);
		cpl(4, RID, 0, 0, 6, 0, 4, 3, 1);
		req(5, 3);
		cpl(5, RID ^ 16'h1, 0, 0, 8, 0, 4, 4, 0);
		req(6, 3);
		cpl(6, RID, 0, 0, 8, 2, 4, 5, 0);
		cpl(9, RID, 0, 0, 8, 0, 4, 6, 0);
		req(7, 3);
		cpl(7, RID, 0, 0, 8, 0, 12, 7, 1);
		req(8, 3);
		cpl(8, RID, 0, 0, 16, 0, 4, 7, 1);
		chk("dropping", USR.dropping[15:0], 16'h0260);
		rdchk("errs", 4'h8, 32'h8);
		rdchk("stat", 4'h4, 32'h200);
	endtask

	task automatic t_dummies();
		flr_valid <= 1;
		flr_func <= 8'h3;
		@(posedge clk);
		flr_valid <= 0;
		dum(5, 3, 4'h8);
		dum(6, 3, 4'h8);
		@(posedge clk);
		bus(1, 4'h0, 32'h1);
		req(2, 4);
		dum(2, 4, 4'h9);
		chk("dropping", USR.dropping[15:0], 16'h0200);
		@(posedge clk);
	endtask

	task automatic t_payload();
		pld_valid <= 1;
		pld_rd_err <= 1;
		@(posedge clk);
		pld_rd_err <= 0;
		pld_last <= 1;
		pld_sof1 <= 1;
		@(posedge clk);
		pld_valid <= 0;
		@(negedge clk);
		chk("sideband", {beat_valid, requester_completion_sideband}, 4'hb);
		@(posedge clk);
		pld_valid <= 1;
		@(posedge clk);
		pld_valid <= 0;
		@(negedge clk);
		chk("sideband", {beat_valid, requester_completion_sideband}, 4'he);
		chk("dropped", drop_cnt, 1);
		@(posedge clk);
		rdchk("fatal", 4'h4, 32'h1);
		bus(1, 4'h4, 32'h1);
		rdchk("fatal", 4'h4, 32'h0);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		rdchk("ctrl", 4'h0, 32'h1);
		rdchk("unmapped", 4'hc, 32'h0);
		bus(1, 4'h0, 32'h0);
		bus(1, 4'h8, 32'h5);
		t_checks();
		t_dummies();
		t_payload();
		report_and_stop();
	end
endmodule
